// [pkg/adccal_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the calibration bank
// Assumes: 50 MHz core clock
// Notes:   Included by bare name; definitions only
`ifndef ADCCAL_CFG_SVH
`define ADCCAL_CFG_SVH
// Register offsets
`define ADCCAL_OFF_GAIN_BASE   8'h00
`define ADCCAL_OFF_OFFS_BASE   8'h10
`define ADCCAL_OFF_CONFIG      8'h20
`define ADCCAL_OFF_SETUP       8'h24
`define ADCCAL_OFF_STATUS      8'h28
`define ADCCAL_OFF_START       8'h2C
// Configuration fields
`define ADCCAL_CFG_OGS_BIT     20
`define ADCCAL_CFG_FRS_BIT     19
// Setup fields, 16-bit setup
`define ADCCAL_SU_CS_HI        15
`define ADCCAL_SU_CS_LO        14
`define ADCCAL_SU_DT_BIT       3
`define ADCCAL_SU_OCD_BIT      2
`define ADCCAL_SU_OG_HI        1
`define ADCCAL_SU_OG_LO        0
// Reset values and write masks
`define ADCCAL_GAIN_RESET      32'h0100_0000
`define ADCCAL_OFFS_RESET      32'h0000_0000
`define ADCCAL_GAIN_MASK       32'h3FFF_FFFF
`define ADCCAL_OFFS_MASK       32'hFFFF_FF00
// Start delay in master-clock cycles
`define ADCCAL_DELAY_FRS0      1280
`define ADCCAL_DELAY_FRS1      1536
`endif

// [pkg/adccal_pkg.sv]
// Purpose: Types shared by the calibration bank modules
// Assumes: Four physical channels
// Notes:   Constants live in adccal_cfg.svh
package adccal_pkg;
   typedef logic [1:0]  adccal_chan_t;
   typedef logic [31:0] adccal_word_t;
   typedef enum logic [1:0] {
      ADCCAL_IDLE  = 2'b00,
      ADCCAL_WAIT  = 2'b01,
      ADCCAL_GO    = 2'b10
   } adccal_state_e;
endpackage

// [pkg/adccal_sel_if.sv]
// Purpose: Coefficient selection bundle between bank and selector
// Assumes: One clock domain
// Notes:   Plain wires, no clocking
`timescale 1ns/10ps
interface adccal_sel_if;
   logic                 src_ptr;      // Pointer select
   adccal_pkg::adccal_chan_t phys_ch;  // Setup channel field
   adccal_pkg::adccal_chan_t ptr_ch;   // Setup pointer field
   adccal_pkg::adccal_chan_t coef_ch;  // Resolved channel
   modport bank (output src_ptr, output phys_ch, output ptr_ch, input coef_ch);
   modport sel  (input src_ptr, input phys_ch, input ptr_ch, output coef_ch);
endinterface

// [hw/adccal_coef_sel.sv]
// Purpose: Resolve which channel's coefficient pair serves a conversion
// Assumes: Binary pointer encoding
// Notes:   Pure combinational
`timescale 1ns/10ps
module adccal_coef_sel (
   adccal_sel_if.sel sel_if   // Selection bundle
);
   // Pointer wins only while the source select is set
   always_comb begin
      if (sel_if.src_ptr) begin
         sel_if.coef_ch = sel_if.ptr_ch;
      end else begin
         sel_if.coef_ch = sel_if.phys_ch;
      end
   end
endmodule

// [hw/adccal_start_delay.sv]
// Purpose: Hold off a conversion start for the settling delay
// Assumes: Start request is a one-cycle pulse
// Notes:   A new request during the wait is ignored
`timescale 1ns/10ps
`include "adccal_cfg.svh"
module adccal_start_delay (
   input  wire logic core_clk_i,   // Core clock
   input  wire logic rst_n_i,      // Async reset, low
   input  wire logic req_i,        // Start request pulse
   input  wire logic delay_en_i,   // Delay enabled for setup
   input  wire logic rate_sel_i,   // Rate scale select
   output logic      busy_o,       // Waiting
   output logic      start_o       // Conversion start pulse
);
   localparam logic [10:0] DLY0 = 11'(`ADCCAL_DELAY_FRS0);
   localparam logic [10:0] DLY1 = 11'(`ADCCAL_DELAY_FRS1);
   adccal_pkg::adccal_state_e state_q;
   logic [10:0]               cnt_q;

   // Sequence: idle, count down, fire
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= adccal_pkg::ADCCAL_IDLE;
         cnt_q   <= 11'h000;
      end else begin
         case (state_q)
            adccal_pkg::ADCCAL_IDLE: begin
               if (req_i && delay_en_i) begin
                  state_q <= adccal_pkg::ADCCAL_WAIT;
                  // Full count loaded: the immediate start already costs one cycle,
                  // so the pulse lands exactly the delay later than without it
                  cnt_q   <= rate_sel_i ? DLY1 : DLY0;
               end else if (req_i) begin
                  state_q <= adccal_pkg::ADCCAL_GO;
               end
            end
            adccal_pkg::ADCCAL_WAIT: begin
               if (cnt_q == 11'h001) begin
                  state_q <= adccal_pkg::ADCCAL_GO;
               end
               cnt_q <= cnt_q - 11'h001;
            end
            adccal_pkg::ADCCAL_GO: begin
               state_q <= adccal_pkg::ADCCAL_IDLE;
            end
            default: begin
               state_q <= adccal_pkg::ADCCAL_IDLE;
            end
         endcase
      end
   end

   assign busy_o  = (state_q != adccal_pkg::ADCCAL_IDLE);
   assign start_o = (state_q == adccal_pkg::ADCCAL_GO);
endmodule

// [hw/adccal_bank.sv]
// Purpose: Per-channel gain and offset coefficient bank with setup interpretation
// Assumes: Single 50 MHz clock, simple strobe register port
// Notes:   Registers read one cycle after the read strobe
`timescale 1ns/10ps
`include "adccal_cfg.svh"
module adccal_bank (
   input  wire logic        core_clk_i,      // Core clock, 50 MHz
   input  wire logic        rst_n_i,         // Async reset, low
   input  wire logic [7:0]  reg_addr_i,      // Byte address
   input  wire logic [31:0] reg_wdata_i,     // Write data
   input  wire logic        reg_wr_i,        // Write strobe
   input  wire logic        reg_rd_i,        // Read strobe
   output logic      [31:0] reg_rdata_o,     // Read data, cycle after strobe
   input  wire logic [31:0] conv_data_i,     // Raw conversion word, MSB aligned
   output logic      [31:0] corr_data_o,     // Corrected conversion word
   output logic      [31:0] gain_coef_o,     // Active gain coefficient
   output logic      [31:0] offs_coef_o,     // Active offset coefficient
   output logic      [1:0]  coef_chan_o,     // Channel of active coefficients
   output logic      [3:0]  open_input_probe_enable_o, // Probe per positive_analog_input
   output logic             rate_scale_select_o,       // Rate scale select level
   output logic             conv_start_o,    // Conversion start pulse
   output logic             start_busy_o     // Start delay in progress
);
   // ******************************************************************
   // Storage
   // ******************************************************************
   adccal_pkg::adccal_word_t gain_q [4];
   adccal_pkg::adccal_word_t offs_q [4];
   logic [31:0]              config_q;
   logic [15:0]              setup_q;
   logic [31:0]              rdata_q;
   logic [31:0]              corr_q;
   logic                     start_req_q;

   adccal_sel_if sel_if ();

   // ******************************************************************
   // Coefficient registers
   // ******************************************************************
   // Masks keep unused gain bits and low offset bits at zero on every write
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_chan
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               gain_q[ch] <= `ADCCAL_GAIN_RESET;
               offs_q[ch] <= `ADCCAL_OFFS_RESET;
            end else if (reg_wr_i) begin
               if (reg_addr_i == `ADCCAL_OFF_GAIN_BASE + 8'(ch * 4)) begin
                  gain_q[ch] <= reg_wdata_i & `ADCCAL_GAIN_MASK;
               end
               if (reg_addr_i == `ADCCAL_OFF_OFFS_BASE + 8'(ch * 4)) begin
                  offs_q[ch] <= reg_wdata_i & `ADCCAL_OFFS_MASK;
               end
            end
         end
      end
   endgenerate

   // ******************************************************************
   // Configuration and setup
   // ******************************************************************
   // Only the two used configuration bits are stored; the rest read zero
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         config_q <= 32'h0000_0000;
         setup_q  <= 16'h0000;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `ADCCAL_OFF_CONFIG) begin
            config_q <= 32'h0000_0000;
            config_q[`ADCCAL_CFG_OGS_BIT] <= reg_wdata_i[`ADCCAL_CFG_OGS_BIT];
            config_q[`ADCCAL_CFG_FRS_BIT] <= reg_wdata_i[`ADCCAL_CFG_FRS_BIT];
         end
         if (reg_addr_i == `ADCCAL_OFF_SETUP) begin
            setup_q <= reg_wdata_i[15:0];
         end
      end
   end

   // Start request comes from a write to the start register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_req_q <= 1'b0;
      end else begin
         start_req_q <= reg_wr_i && (reg_addr_i == `ADCCAL_OFF_START) && reg_wdata_i[0];
      end
   end

   // ******************************************************************
   // Coefficient selection
   // ******************************************************************
   assign sel_if.src_ptr = config_q[`ADCCAL_CFG_OGS_BIT];
   assign sel_if.phys_ch = setup_q[`ADCCAL_SU_CS_HI:`ADCCAL_SU_CS_LO];
   assign sel_if.ptr_ch  = setup_q[`ADCCAL_SU_OG_HI:`ADCCAL_SU_OG_LO];

   adccal_coef_sel u_sel (
      .sel_if (sel_if.sel)
   );

   assign coef_chan_o = sel_if.coef_ch;
   assign gain_coef_o = gain_q[sel_if.coef_ch];
   assign offs_coef_o = offs_q[sel_if.coef_ch];
   assign rate_scale_select_o = config_q[`ADCCAL_CFG_FRS_BIT];

   // ******************************************************************
   // Open input probe
   // ******************************************************************
   // Probe follows the physical channel field, not the coefficient pointer
   always_comb begin
      open_input_probe_enable_o = 4'h0;
      if (setup_q[`ADCCAL_SU_OCD_BIT]) begin
         open_input_probe_enable_o[sel_if.phys_ch] = 1'b1;
      end
   end

   // ******************************************************************
   // Start delay
   // ******************************************************************
   adccal_start_delay u_dly (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .req_i      (start_req_q),
      .delay_en_i (setup_q[`ADCCAL_SU_DT_BIT]),
      .rate_sel_i (config_q[`ADCCAL_CFG_FRS_BIT]),
      .busy_o     (start_busy_o),
      .start_o    (conv_start_o)
   );

   // ******************************************************************
   // Correction datapath
   // ******************************************************************
   // Offset is signed and MSB aligned with data; the gain scales the
   // offset-corrected word. Result saturates nowhere: host keeps gain <= 40.
   // Both operands are widened to 64 bits so the product is never cut short
   logic signed [63:0] diff_s;
   logic signed [63:0] prod_s;
   always_comb begin
      diff_s = $signed({{32{conv_data_i[31]}}, conv_data_i})
             - $signed({{32{offs_coef_o[31]}}, offs_coef_o});
      prod_s = diff_s * $signed({32'h0000_0000, gain_coef_o});
   end

   // Fixed point gain has 24 fraction bits
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         corr_q <= 32'h0000_0000;
      end else begin
         corr_q <= prod_s[55:24];
      end
   end
   assign corr_data_o = corr_q;

   // ******************************************************************
   // Register read port
   // ******************************************************************
   // Unmapped addresses read zero
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `ADCCAL_OFF_GAIN_BASE + 8'h00: rdata_q <= gain_q[0];
            `ADCCAL_OFF_GAIN_BASE + 8'h04: rdata_q <= gain_q[1];
            `ADCCAL_OFF_GAIN_BASE + 8'h08: rdata_q <= gain_q[2];
            `ADCCAL_OFF_GAIN_BASE + 8'h0C: rdata_q <= gain_q[3];
            `ADCCAL_OFF_OFFS_BASE + 8'h00: rdata_q <= offs_q[0];
            `ADCCAL_OFF_OFFS_BASE + 8'h04: rdata_q <= offs_q[1];
            `ADCCAL_OFF_OFFS_BASE + 8'h08: rdata_q <= offs_q[2];
            `ADCCAL_OFF_OFFS_BASE + 8'h0C: rdata_q <= offs_q[3];
            `ADCCAL_OFF_CONFIG:            rdata_q <= config_q;
            `ADCCAL_OFF_SETUP:             rdata_q <= {16'h0000, setup_q};
            `ADCCAL_OFF_STATUS:            rdata_q <= {29'h0000_0000, start_busy_o,
                                                       sel_if.coef_ch};
            default:                       rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign reg_rdata_o = rdata_q;
endmodule

// [testbench/adccal_bank_props.sv]
// Purpose: Concurrent checks on the calibration bank ports
// Assumes: One clock, asynchronous active-low reset
// Notes:   Attached to adccal_bank by the bind below
`timescale 1ns/10ps
module adccal_bank_props (
   input  wire logic        core_clk_i,                 // Core clock
   input  wire logic        rst_n_i,                    // Reset, low
   input  wire logic [7:0]  reg_addr_i,                 // Register address
   input  wire logic        reg_rd_i,                   // Read strobe
   input  wire logic [31:0] reg_rdata_o,                // Read data
   input  wire logic [31:0] conv_data_i,                // Raw word
   input  wire logic [31:0] corr_data_o,                // Corrected word
   input  wire logic [31:0] gain_coef_o,                // Active gain
   input  wire logic [31:0] offs_coef_o,                // Active offset
   input  wire logic [3:0]  open_input_probe_enable_o,  // Probe enables
   input  wire logic        rate_scale_select_o,        // Rate scale level
   input  wire logic        conv_start_o,               // Start pulse
   input  wire logic        start_busy_o                // Waiting
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [10:0] wait_q;
   // Busy length; saturates so a stuck wait cannot wrap back to a legal count
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) wait_q <= 11'h000;
      else if (!start_busy_o) wait_q <= 11'h000;
      else if (wait_q != 11'h7FF) wait_q <= wait_q + 11'h001;
   end
   // Gain-scaled correction: the offset is removed before the gain multiply
   function automatic logic [31:0] corr_f(input logic [31:0] c, o, g);
      logic signed [63:0] p;
      p = ($signed({{32{c[31]}}, c}) - $signed({{32{o[31]}}, o})) * $signed({32'h0, g});
      return p[55:24];
   endfunction
   sequence s_rd_gain;
      reg_rd_i && reg_addr_i[7:4] == 4'h0;
   endsequence
   sequence s_rd_offs;
      reg_rd_i && reg_addr_i[7:4] == 4'h1;
   endsequence
   AST_START_DELAY: assert property (conv_start_o |-> wait_q == 11'h000 ||
      wait_q == (rate_scale_select_o ? 11'h600 : 11'h500)) else $error("start delay count wrong");
   AST_WAIT_MAX: assert property (start_busy_o |-> wait_q <= 11'h600) else $error("start wait too long");
   AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o) else $error("start pulse long");
   AST_PULSE_BUSY: assert property (conv_start_o |-> start_busy_o) else $error("pulse without busy");
   AST_GAIN_TOP: assert property (gain_coef_o[31:30] == 2'b00) else $error("gain top bits set");
   AST_OFFS_LOW: assert property (offs_coef_o[7:0] == 8'h00) else $error("offset low bits set");
   AST_RD_GAIN: assert property (s_rd_gain |=> reg_rdata_o[31:30] == 2'b00) else $error("gain read");
   AST_RD_OFFS: assert property (s_rd_offs |=> reg_rdata_o[7:0] == 8'h00) else $error("offset read");
   AST_PROBE: assert property ($onehot0(open_input_probe_enable_o)) else $error("probe not one-hot");
   AST_CORR: assert property ($past(rst_n_i) |-> corr_data_o == corr_f($past(conv_data_i),
      $past(offs_coef_o), $past(gain_coef_o))) else $error("corrected word wrong");
endmodule
bind adccal_bank adccal_bank_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .conv_data_i(conv_data_i), .corr_data_o(corr_data_o), .gain_coef_o(gain_coef_o),
   .offs_coef_o(offs_coef_o), .open_input_probe_enable_o(open_input_probe_enable_o),
   .rate_scale_select_o(rate_scale_select_o), .conv_start_o(conv_start_o),
   .start_busy_o(start_busy_o));

// [testbench/adccal_host_model.sv]
// Purpose: Host register-port master for the calibration bank
// Assumes: One-cycle strobes, read data in the cycle after the strobe
// Notes:   After the time-zero idle values, signals change only by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module adccal_host_model (
   input  wire logic        core_clk_i,  // Core clock
   output logic      [7:0]  addr_o,      // Register address
   output logic      [31:0] wdata_o,     // Write data
   output logic             wr_o,        // Write strobe
   output logic             rd_o,        // Read strobe
   input  wire logic [31:0] rdata_i      // Read data
);
   // Idle bus from time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0000_0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // Gain words never exceed 40.0, though the format reaches nearly 64
   function automatic logic [31:0] gain_lim(input logic [31:0] v);
      return (v[29:0] > 30'h2800_0000) ? {v[31:30], 30'h2800_0000} : v;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_o <= a;
      wdata_o <= (a < 8'h10) ? gain_lim(d) : d;
      wr_o <= 1'b1;
      @(posedge core_clk_i);
      wr_o <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      @(negedge core_clk_i);
      d = rdata_i;
   endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the calibration bank
// Assumes: 50 MHz clock, host model drives the register port
// Notes:   Coefficient model kept in arrays, compared at every result
`timescale 1ns/10ps
`include "adccal_cfg.svh"
module tb_top;
   logic        core_clk_i;
   logic        rst_n_i;
   logic [31:0] conv_data_i;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, corr, gain, offs, d, cv;
   logic        wr, rd, rate, start, busy;
   logic [1:0]  chan, ch;
   logic [3:0]  probe;
   logic [31:0] gain_m [4];
   logic [31:0] offs_m [4];
   logic [31:0] rs = 32'h0000_E1FB;
   int          n_mismatch = 0, checks = 0, i, k, n;
   longint      p;
   adccal_host_model host (.core_clk_i(core_clk_i), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   adccal_bank uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .conv_data_i(conv_data_i), .corr_data_o(corr), .gain_coef_o(gain), .offs_coef_o(offs),
      .coef_chan_o(chan), .open_input_probe_enable_o(probe), .rate_scale_select_o(rate),
      .conv_start_o(start), .start_busy_o(busy));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // 20 ns clock
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // Watchdog well beyond the two long start waits
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_mismatch++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      conv_data_i = 32'h0000_0000;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 4; i++) begin
         host.rd(`ADCCAL_OFF_GAIN_BASE + 8'(i << 2), d);
         chk("gain reset", d, 32'h0100_0000);
         host.rd(`ADCCAL_OFF_OFFS_BASE + 8'(i << 2), d);
         chk("offset reset", d, 32'h0000_0000);
      end
      host.rd(8'h40, d);
      chk("unmapped read", d, 32'h0000_0000);
      $display("test reset done");
      // Unused bits are written high and must not be kept
      for (i = 0; i < 4; i++) begin
         d = xs();
         gain_m[i] = {3'b110, d[28:0]};
         offs_m[i] = xs() | 32'h0000_00FF;
         host.wr(`ADCCAL_OFF_GAIN_BASE + 8'(i << 2), gain_m[i]);
         host.wr(`ADCCAL_OFF_OFFS_BASE + 8'(i << 2), offs_m[i]);
         gain_m[i] = gain_m[i] & 32'h3FFF_FFFF;
         offs_m[i] = offs_m[i] & 32'hFFFF_FF00;
      end
      for (i = 0; i < 4; i++) begin
         host.rd(`ADCCAL_OFF_GAIN_BASE + 8'(i << 2), d);
         chk("gain readback", d, gain_m[i]);
         host.rd(`ADCCAL_OFF_OFFS_BASE + 8'(i << 2), d);
         chk("offset readback", d, offs_m[i]);
      end
      $display("test coefficients done");
      // Every source mode, channel field and pointer, then one corrected word
      for (k = 0; k < 32; k++) begin
         d = xs();
         host.wr(`ADCCAL_OFF_CONFIG, {11'h000, k[4], 20'h00000});
         host.wr(`ADCCAL_OFF_SETUP, {16'h0000, k[3:2], 10'h000, 1'b0, d[0], k[1:0]});
         @(negedge core_clk_i);
         ch = k[4] ? k[1:0] : k[3:2];
         chk("coefficient channel", {30'h0, chan}, {30'h0, ch});
         chk("active gain", gain, gain_m[ch]);
         chk("active offset", offs, offs_m[ch]);
         chk("probe enable", {28'h0, probe}, d[0] ? 32'h1 << k[3:2] : 32'h0);
         @(posedge core_clk_i);
         cv = xs();
         conv_data_i <= cv;
         @(posedge core_clk_i);
         @(negedge core_clk_i);
         p = (longint'($signed(cv)) - longint'($signed(offs_m[ch]))) * longint'(gain_m[ch]);
         chk("corrected word", corr, p[55:24]);
      end
      $display("test selection done");
      // Both rate settings with and without the delay bit
      for (k = 0; k < 4; k++) begin
         host.wr(`ADCCAL_OFF_CONFIG, {12'h000, k[0], 19'h00000});
         host.wr(`ADCCAL_OFF_SETUP, {16'h0000, 2'b00, 10'h000, k[1], 3'b000});
         chk("rate scale", {31'h0, rate}, {31'h0, k[0]});
         host.wr(`ADCCAL_OFF_START, 32'h0000_0001);
         // Counts negedges until the pulse; two of them belong to the request path
         for (n = 0; n < 1700 && start !== 1'b1; n++) @(negedge core_clk_i);
         chk("start delay", 32'(n), 32'(k[1] ? (k[0] ? 1536 : 1280) + 2 : 2));
         chk("busy at start", {31'h0, busy}, 32'h0000_0001);
         repeat (3) @(posedge core_clk_i);
         host.rd(`ADCCAL_OFF_STATUS, d);
         chk("status idle", d, 32'h0000_0000);
      end
      $display("test start delay done");
      tally_and_finish;
   end
endmodule
